// *** hw/serial_status_flags.sv ***
// Purpose: Status flag logic of one serial channel with Avalon-MM access
// Assumes: Receive and transmit shifters are outside and report by pulses
// Notes: Software clears a flag only by writing 0 after reading the same flag as 1
//
// Summary of operation
// - Character completes while receive-full is set: set overrun.
// - Overrun clears on reset, standby, or 0 write after reading 1.
// - On overrun keep old holding data; reception halts while overrun set.
// - Synchronous mode: any error flag blocks transmission.
// - Clearing receive-enable leaves error flags unchanged.
// - Asynchronous mode: first stop bit 0 sets framing error.
// - With two stop bits only the first is checked.
// - Framing error: data loaded, receive-full not set, reception halts.
// - Parity error: data loaded, receive-full not set, reception halts.
// - Asynchronous parity: ones count mismatch with odd/even sets parity error.
// - Framing and parity flags clear on reset, standby, or 0 after 1 read.
// - Transmit-end sets on reset, standby, tx-enable clear, or empty at last bit.
// - Transmit-end clears on transmit-empty clear or DMA holding write.
// - Transmit-end is read-only.
// - Async multiprocessor format captures received bit; read-only.
// - Clearing receive-enable keeps the captured multiprocessor bit.
// - Async multiprocessor transmit appends the writable transmit bit.
// - Transmit multiprocessor bit ignored in sync, non-multiproc, or idle.
// - Whole status register resets to 84 hex on reset and standby.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
module serial_status_flags
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic standby,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Receive shifter side
   input wire logic rx_done,
   input wire serial_status_pkg::rx_char_t rx_char,
   output logic rx_halt,
   // Transmit shifter side
   input wire logic tx_take,
   input wire logic tx_last_bit,
   input wire logic tx_busy,
   output logic tx_block,
   output logic tx_data_valid,
   output logic [7:0] tx_data,
   output logic tx_mpb_out,
   // DMA unit side
   input wire logic dma_tx_write,
   input wire logic [7:0] dma_tx_data,
   input wire logic dma_rx_read,
   output logic [7:0] rx_data,
   // Flag outputs
   output logic [7:0] status_out
);

   serial_status_pkg::state_t s_r;
   serial_status_pkg::state_t s_nxt;

   function automatic logic is_addr(input logic [3:0] a, input logic [3:0] ofs);
      is_addr = (a == ofs);
   endfunction

   // ***********************************
   // Flag and register update
   // ***********************************
   logic rd_req;
   logic wr_req;
   logic async_mode;
   logic perr;
   logic ferr;
   logic any_err;
   logic [7:0] wd;
   logic rx_accept;
   logic tx_sw_load;

   // Read data are captured at the request edge; a write acts only at the answer edge
   assign rd_req = avs_read && !s_r.ack;
   assign wr_req = avs_write && s_r.ack && avs_byteenable[0];
   assign async_mode = !s_r.control[serial_status_pkg::CTL_SYNC_MODE];
   assign any_err = s_r.status[serial_status_pkg::BIT_OVERRUN]
      | s_r.status[serial_status_pkg::BIT_FRAMING]
      | s_r.status[serial_status_pkg::BIT_PARITY];
   assign wd = avs_writedata[7:0];
   assign ferr = async_mode && !rx_char.stop1;
   assign perr = async_mode && s_r.control[serial_status_pkg::CTL_PARITY_EN]
      && ((^{rx_char.data, rx_char.parity}) != s_r.control[serial_status_pkg::CTL_PARITY_ODD]);
   // Any set error flag halts reception until software clears it
   assign rx_accept = rx_done && s_r.control[serial_status_pkg::CTL_RX_ENABLE] && !any_err;
   assign tx_sw_load = wr_req && is_addr(avs_address, serial_status_pkg::OFS_STATUS)
      && !wd[serial_status_pkg::BIT_TX_EMPTY]
      && s_r.seen_one[serial_status_pkg::BIT_TX_EMPTY]
      && s_r.status[serial_status_pkg::BIT_TX_EMPTY];

   always_comb
   begin
      logic accept;
      logic clr_empty;
      accept = 1'b0;
      clr_empty = 1'b0;
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      // Read returns the value held before this cycle's updates
      if (rd_req)
      begin
         s_nxt.ack = 1'b1;
         if (is_addr(avs_address, serial_status_pkg::OFS_STATUS))
         begin
            s_nxt.rdata = {24'h000000, s_r.status};
         end
         else if (is_addr(avs_address, serial_status_pkg::OFS_CONTROL))
            s_nxt.rdata = {24'h000000, s_r.control};
         else
            s_nxt.rdata = 32'h00000000;
      end
      if (avs_write && !s_r.ack)
         s_nxt.ack = 1'b1;
      // A flag counts as read as 1 only when the read completes with it shown set
      if (avs_read && s_r.ack && is_addr(avs_address, serial_status_pkg::OFS_STATUS))
         s_nxt.seen_one = s_r.seen_one | s_r.rdata[7:0];
      // Software side: 0 clears a flag only after it was seen as 1
      if (wr_req && is_addr(avs_address, serial_status_pkg::OFS_STATUS))
      begin
         // bits 2 and 1 are left out, so software never reaches them
         for (int i = 3; i <= 7; i++)
         begin
            if (!wd[i] && s_r.seen_one[i] && s_r.status[i])
            begin
               s_nxt.status[i] = 1'b0;
               s_nxt.seen_one[i] = 1'b0;
            end
         end
         clr_empty = tx_sw_load;
         s_nxt.status[serial_status_pkg::BIT_TX_MPB] = wd[serial_status_pkg::BIT_TX_MPB];
      end
      if (wr_req && is_addr(avs_address, serial_status_pkg::OFS_CONTROL))
         s_nxt.control = wd;
      // Transmit holding: software load in the write that clears empty, or DMA
      if (clr_empty)
      begin
         s_nxt.tx_holding_reg = avs_writedata[15:8];
         s_nxt.tx_load = 1'b1;
         s_nxt.status[serial_status_pkg::BIT_TX_END] = 1'b0;
      end
      if (dma_tx_write)
      begin
         s_nxt.tx_holding_reg = dma_tx_data;
         s_nxt.tx_load = 1'b1;
         s_nxt.status[serial_status_pkg::BIT_TX_EMPTY] = 1'b0;
         s_nxt.status[serial_status_pkg::BIT_TX_END] = 1'b0;
      end
      if (dma_rx_read)
         s_nxt.status[serial_status_pkg::BIT_RX_FULL] = 1'b0;
      if (tx_take && s_r.tx_load)
      begin
         s_nxt.tx_load = 1'b0;
         s_nxt.status[serial_status_pkg::BIT_TX_EMPTY] = 1'b1;
         s_nxt.tx_mpb_out = async_mode && s_r.control[serial_status_pkg::CTL_MULTIPROC]
            && s_r.status[serial_status_pkg::BIT_TX_MPB];
      end
      if (tx_last_bit && s_r.status[serial_status_pkg::BIT_TX_EMPTY])
         s_nxt.status[serial_status_pkg::BIT_TX_END] = 1'b1;
      if (!s_r.control[serial_status_pkg::CTL_TX_ENABLE])
      begin
         s_nxt.status[serial_status_pkg::BIT_TX_EMPTY] = 1'b1;
         s_nxt.status[serial_status_pkg::BIT_TX_END] = 1'b1;
         s_nxt.tx_load = 1'b0;
      end
      // Receive completion; events set after clears so set wins
      // receive-enable low only stops new captures
      accept = rx_accept;
      if (accept)
      begin
         if (s_r.status[serial_status_pkg::BIT_RX_FULL])
            s_nxt.status[serial_status_pkg::BIT_OVERRUN] = 1'b1;
         else
         begin
            s_nxt.rx_holding_reg = rx_char.data;
            if (ferr)
               s_nxt.status[serial_status_pkg::BIT_FRAMING] = 1'b1;
            if (perr)
               s_nxt.status[serial_status_pkg::BIT_PARITY] = 1'b1;
            if (!ferr && !perr)
               s_nxt.status[serial_status_pkg::BIT_RX_FULL] = 1'b1;
            if (async_mode && s_r.control[serial_status_pkg::CTL_MULTIPROC])
               s_nxt.status[serial_status_pkg::BIT_RX_MPB] = rx_char.rx_multiproc_bit;
         end
      end
      if (srst || standby)
      begin
         s_nxt.status = serial_status_pkg::STATUS_RESET;
         s_nxt.seen_one = 8'h00;
         s_nxt.tx_load = 1'b0;
         s_nxt.tx_mpb_out = 1'b0;
      end
      if (srst)
      begin
         s_nxt.control = serial_status_pkg::CONTROL_RESET;
         s_nxt.rx_holding_reg = 8'h00;
         s_nxt.tx_holding_reg = 8'h00;
         s_nxt.rdata = 32'h00000000;
         s_nxt.ack = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      s_r <= s_nxt;
   end

   // ***********************************
   // Outputs
   // ***********************************
   // Waitrequest drops one cycle after the request: one wait state per access
   assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
   assign avs_readdata = s_r.rdata;
   assign rx_halt = any_err;
   // Transmission blocked only in synchronous mode by errors
   assign tx_block = !async_mode && any_err;
   assign tx_data_valid = s_r.tx_load && !tx_block;
   assign tx_data = s_r.tx_holding_reg;
   assign tx_mpb_out = s_r.tx_mpb_out;
   assign rx_data = s_r.rx_holding_reg;
   assign status_out = s_r.status;

   // ***********************************
   // Checks
   // ***********************************
   // Character finishes while the holding register is still full
   sequence rx_into_full;
      rx_accept && s_r.status[serial_status_pkg::BIT_RX_FULL] && !srst && !standby;
   endsequence

   // Character finishes into an empty holding register
   sequence rx_into_empty;
      rx_accept && !s_r.status[serial_status_pkg::BIT_RX_FULL] && !srst && !standby;
   endsequence

   // Shifter takes the holding character
   sequence tx_handover;
      tx_take && s_r.tx_load && !srst && !standby;
   endsequence

   // ***********************************
   // Receive flag checks
   // ***********************************
   chk_overrun_set: assert property (@(posedge clk) disable iff (srst)
      rx_into_full |=> s_r.status[serial_status_pkg::BIT_OVERRUN])
      else $error("overrun not set");
   chk_overrun_keeps: assert property (@(posedge clk) disable iff (srst)
      rx_into_full |=> $stable(rx_data))
      else $error("holding data overwritten");
   chk_frame_set: assert property (@(posedge clk) disable iff (srst)
      rx_into_empty ##0 ferr |=> s_r.status[serial_status_pkg::BIT_FRAMING])
      else $error("framing error not set");
   chk_frame_hold: assert property (@(posedge clk) disable iff (srst)
      rx_into_empty ##0 ferr
      |=> !s_r.status[serial_status_pkg::BIT_RX_FULL] && rx_data == $past(rx_char.data))
      else $error("framing error load wrong");
   chk_parity_set: assert property (@(posedge clk) disable iff (srst)
      rx_into_empty ##0 perr |=> s_r.status[serial_status_pkg::BIT_PARITY])
      else $error("parity error not set");
   chk_clean_full: assert property (@(posedge clk) disable iff (srst)
      rx_into_empty ##0 (!ferr && !perr) |=> s_r.status[serial_status_pkg::BIT_RX_FULL])
      else $error("clean character not marked full");
   chk_halt_err: assert property (@(posedge clk) disable iff (srst)
      s_r.status[serial_status_pkg::BIT_PARITY] |-> rx_halt)
      else $error("rx not halted");
   chk_halt_hold: assert property (@(posedge clk) disable iff (srst)
      (any_err && rx_done && !standby) |=> $stable(rx_data))
      else $error("halted receiver loaded data");
   chk_rxen_keep: assert property (@(posedge clk) disable iff (srst)
      (!s_r.control[serial_status_pkg::CTL_RX_ENABLE] && !standby && !avs_write)
      |=> $stable({s_r.status[5:3], s_r.status[1]}))
      else $error("flags changed with rx off");
   chk_mpb_capture: assert property (@(posedge clk) disable iff (srst)
      rx_into_empty ##0 (async_mode && s_r.control[serial_status_pkg::CTL_MULTIPROC])
      |=> s_r.status[serial_status_pkg::BIT_RX_MPB] == $past(rx_char.rx_multiproc_bit))
      else $error("received multiprocessor bit not captured");
   chk_mpb_ro: assert property (@(posedge clk) disable iff (srst)
      (wr_req && !rx_done && !standby) |=> $stable(s_r.status[serial_status_pkg::BIT_RX_MPB]))
      else $error("received multiprocessor bit written");

   // ***********************************
   // Software clear and standby reset checks
   // ***********************************
   chk_one_write: assert property (@(posedge clk) disable iff (srst)
      (wr_req && is_addr(avs_address, serial_status_pkg::OFS_STATUS)
      && wd[serial_status_pkg::BIT_OVERRUN] && !rx_done && !standby)
      |=> $stable(s_r.status[serial_status_pkg::BIT_OVERRUN]))
      else $error("write of 1 changed flag");
   chk_sw_clear: assert property (@(posedge clk) disable iff (srst)
      (wr_req && is_addr(avs_address, serial_status_pkg::OFS_STATUS)
      && !wd[serial_status_pkg::BIT_OVERRUN] && s_r.seen_one[serial_status_pkg::BIT_OVERRUN]
      && s_r.status[serial_status_pkg::BIT_OVERRUN] && !rx_done)
      |=> !s_r.status[serial_status_pkg::BIT_OVERRUN])
      else $error("overrun not cleared");
   chk_sw_clear_frame: assert property (@(posedge clk) disable iff (srst)
      (wr_req && is_addr(avs_address, serial_status_pkg::OFS_STATUS)
      && !wd[serial_status_pkg::BIT_FRAMING] && s_r.seen_one[serial_status_pkg::BIT_FRAMING]
      && s_r.status[serial_status_pkg::BIT_FRAMING] && !rx_done)
      |=> !s_r.status[serial_status_pkg::BIT_FRAMING])
      else $error("framing error not cleared");
   chk_reset_value: assert property (@(posedge clk)
      standby |=> status_out == serial_status_pkg::STATUS_RESET)
      else $error("status not 84 after standby");

   // ***********************************
   // Transmit flag checks
   // ***********************************
   chk_sync_block: assert property (@(posedge clk) disable iff (srst)
      (!async_mode && s_r.status[serial_status_pkg::BIT_FRAMING]) |-> !tx_data_valid)
      else $error("sync tx not blocked");
   chk_async_free: assert property (@(posedge clk) disable iff (srst)
      async_mode |-> !tx_block)
      else $error("async tx blocked by errors");
   chk_transmit_finished_flag_ro: assert property (@(posedge clk) disable iff (srst)
      (s_r.status[serial_status_pkg::BIT_TX_END] && !dma_tx_write && !tx_sw_load)
      |=> s_r.status[serial_status_pkg::BIT_TX_END])
      else $error("tx end changed by write");
   chk_transmit_finished_flag_set: assert property (@(posedge clk) disable iff (srst)
      (tx_last_bit && s_r.status[serial_status_pkg::BIT_TX_EMPTY])
      |=> s_r.status[serial_status_pkg::BIT_TX_END])
      else $error("tx end not set at last bit");
   chk_tx_off: assert property (@(posedge clk) disable iff (srst)
      !s_r.control[serial_status_pkg::CTL_TX_ENABLE]
      |=> s_r.status[serial_status_pkg::BIT_TX_END] && s_r.status[serial_status_pkg::BIT_TX_EMPTY])
      else $error("tx end not set with tx off");
   chk_transmit_finished_flag_clear: assert property (@(posedge clk) disable iff (srst)
      (dma_tx_write && !tx_last_bit && s_r.control[serial_status_pkg::CTL_TX_ENABLE] && !standby)
      |=> !s_r.status[serial_status_pkg::BIT_TX_END])
      else $error("tx end not cleared by dma write");
   chk_mpb_append: assert property (@(posedge clk) disable iff (srst)
      tx_handover ##0 (async_mode && s_r.control[serial_status_pkg::CTL_MULTIPROC])
      |=> tx_mpb_out == $past(s_r.status[serial_status_pkg::BIT_TX_MPB]))
      else $error("transmit multiprocessor bit not appended");
   chk_mpb_ignored: assert property (@(posedge clk) disable iff (srst)
      tx_handover ##0 (!async_mode || !s_r.control[serial_status_pkg::CTL_MULTIPROC])
      |=> !tx_mpb_out)
      else $error("transmit multiprocessor bit not ignored");

   // ***********************************
   // Bus handshake check
   // ***********************************
   // Exactly one wait state: a pending request is answered in the next cycle
   chk_wait_once: assert property (@(posedge clk) disable iff (srst)
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
      else $error("waitrequest held too long");

endmodule

// *** hw/serial_status_pkg.sv ***
// Purpose: Constants and carrier types for the serial status flag block
// Assumes: 8-bit status register in one Avalon-MM word, control word beside it
// Notes: Bit positions follow the status register layout
package serial_status_pkg;

   // ***********************************
   // Register map (byte addresses)
   // ***********************************
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_CONTROL = 4'h4;

   // ***********************************
   // Status bit positions and reset
   // ***********************************
   localparam int BIT_TX_EMPTY = 7;
   localparam int BIT_RX_FULL = 6;
   localparam int BIT_OVERRUN = 5;
   localparam int BIT_FRAMING = 4;
   localparam int BIT_PARITY = 3;
   localparam int BIT_TX_END = 2;
   localparam int BIT_RX_MPB = 1;
   localparam int BIT_TX_MPB = 0;
   localparam logic [7:0] STATUS_RESET = 8'h84;

   // ***********************************
   // Control bit positions and reset
   // ***********************************
   localparam int CTL_RX_ENABLE = 0;
   localparam int CTL_TX_ENABLE = 1;
   localparam int CTL_SYNC_MODE = 2;
   localparam int CTL_PARITY_EN = 3;
   localparam int CTL_PARITY_ODD = 4;
   localparam int CTL_MULTIPROC = 5;
   localparam int CTL_TWO_STOP = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam int DATA_BITS = 8;

   // Received character as handed over by the receive shifter
   typedef struct packed {
      logic [7:0] data;
      logic parity;
      logic stop1;
      logic stop2;
      logic rx_multiproc_bit;
   } rx_char_t;

   // Whole block state
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] control;
      logic [7:0] rx_holding_reg;
      logic [7:0] tx_holding_reg;
      logic tx_load;
      logic tx_mpb_out;
      logic [7:0] seen_one;
      logic [31:0] rdata;
      logic ack;
   } state_t;

endpackage

// *** tb/serial_far_model.sv ***
// Purpose: Far-side transmit shifter model for the serial status block
// Assumes: Takes an offered holding character as soon as it is not busy
// Notes: GAP sets how slowly the last bit leaves the line
`timescale 1ns/100ps
module serial_far_model
#(
   parameter int GAP = 6
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Holding side
   input wire logic tx_data_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_mpb_out,
   output logic tx_take,
   output logic tx_last_bit,
   output logic tx_busy,
   output logic [8:0] sent
);
   int cnt;
   always @(posedge clk)
   begin
      tx_take <= 1'b0;
      tx_last_bit <= 1'b0;
      if (srst)
         tx_busy <= 1'b0;
      else if (!tx_busy && tx_data_valid)
      begin
         tx_take <= 1'b1;
         tx_busy <= 1'b1;
         sent[7:0] <= tx_data;
         cnt <= GAP;
      end
      else if (tx_busy && cnt == 1)
      begin
         // Appended bit sampled late, as the line carries it last
         sent[8] <= tx_mpb_out;
         tx_last_bit <= 1'b1;
         tx_busy <= 1'b0;
      end
      else if (tx_busy)
         cnt <= cnt - 1;
   end
endmodule

// *** tb/serial_status_flags_bench.sv ***
// Purpose: Self-checking bench for the serial status flag block
// Assumes: One bus access at a time, far-side shifter model on transmit
// Notes: Flag and data outputs are looked at on the falling edge, away from launch edges; read data at the answer edge
`timescale 1ns/100ps
module serial_status_flags_bench;
   localparam logic [3:0] ST = serial_status_pkg::OFS_STATUS;
   localparam logic [3:0] CT = serial_status_pkg::OFS_CONTROL;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic standby = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic rx_done = 1'b0;
   serial_status_pkg::rx_char_t rx_char = '0;
   logic dma_tx_write = 1'b0;
   logic dma_rx_read = 1'b0;
   logic [7:0] dma_tx_data = 8'h00;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, rx_halt, tx_take, tx_last_bit, tx_busy;
   logic tx_block, tx_data_valid, tx_mpb_out;
   logic [7:0] tx_data, rx_data, status_out;
   logic [8:0] sent;
   logic [31:0] rnd = 32'h7341;
   logic [31:0] expq[$];
   int n_mismatch = 0;
   int n_tests = 0;
   always #10 clk = ~clk;
   serial_status_flags serial_status_flags_inst (.clk(clk), .srst(srst), .standby(standby),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rx_done(rx_done), .rx_char(rx_char),
      .rx_halt(rx_halt), .tx_take(tx_take), .tx_last_bit(tx_last_bit), .tx_busy(tx_busy),
      .tx_block(tx_block), .tx_data_valid(tx_data_valid), .tx_data(tx_data),
      .tx_mpb_out(tx_mpb_out), .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data),
      .dma_rx_read(dma_rx_read), .rx_data(rx_data), .status_out(status_out));
   serial_far_model #(.GAP(6)) serial_far_model_inst (.clk(clk), .srst(srst),
      .tx_data_valid(tx_data_valid), .tx_data(tx_data), .tx_mpb_out(tx_mpb_out),
      .tx_take(tx_take), .tx_last_bit(tx_last_bit), .tx_busy(tx_busy), .sent(sent));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Read notes its expected word; the watcher below compares it
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      if (!wr)
         expq.push_back(d);
      avs_address <= a;
      avs_writedata <= wr ? d : 32'h0;
      avs_write <= wr;
      avs_read <= !wr;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk)
      if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0)
         chk(avs_readdata, expq.pop_front());
   task automatic rx(input logic [7:0] d, input logic p, s1, s2, m);
      rx_done <= 1'b1;
      rx_char <= '{data: d, parity: p, stop1: s1, stop2: s2, rx_multiproc_bit: m};
      @(posedge clk);
      rx_done <= 1'b0;
      @(posedge clk);
   endtask
   task automatic look(input logic [7:0] st, rd, input logic [1:0] fl);
      @(negedge clk);
      chk({24'h0, status_out}, {24'h0, st});
      chk({24'h0, rx_data}, {24'h0, rd});
      chk({30'h0, rx_halt, tx_block}, {30'h0, fl});
      @(posedge clk);
   endtask
   task automatic tx_wait;
      for (int i = 0; i < 60 && !tx_last_bit; i++)
         @(posedge clk);
      @(posedge clk);
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
   initial
   begin
      logic [7:0] d;
      logic [7:0] d2;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      bus(0, ST, 32'h84);
      bus(0, CT, 32'h0);
      bus(1, 4'hC, 32'hFF);
      bus(0, 4'h8, 32'h0);
      // Async, even parity, two stop bits, both directions on
      bus(1, CT, 32'h4B);
      rnd = xs(rnd);
      d = rnd[7:0];
      rx(d, ^d, 1'b1, 1'b0, 1'b0);
      look(8'hC4, d, 2'b00);
      rx(d ^ 8'h0F, ^d, 1'b1, 1'b1, 1'b0);
      look(8'hE4, d, 2'b10);
      bus(1, ST, 32'hDE);
      look(8'hE4, d, 2'b10);
      bus(0, ST, 32'hE4);
      bus(1, ST, 32'hDE);
      look(8'hC4, d, 2'b00);
      dma_rx_read <= 1'b1;
      @(posedge clk);
      dma_rx_read <= 1'b0;
      rnd = xs(rnd);
      d2 = rnd[7:0];
      rx(d2, ^d2, 1'b0, 1'b1, 1'b0);
      look(8'h94, d2, 2'b10);
      bus(1, CT, 32'h4A);
      look(8'h94, d2, 2'b10);
      bus(1, CT, 32'h4E);
      look(8'h94, d2, 2'b11);
      bus(1, CT, 32'h4B);
      bus(0, ST, 32'h94);
      bus(1, ST, 32'hEE);
      look(8'h84, d2, 2'b00);
      for (int odd = 0; odd < 2; odd++)
      begin
         bus(1, CT, 32'h4B | (odd << 4));
         rnd = xs(rnd);
         d = rnd[7:0];
         rx(d, ^d ^ odd[0] ^ 1'b1, 1'b1, 1'b1, 1'b0);
         look(8'h8C, d, 2'b10);
         bus(0, ST, 32'h8C);
         bus(1, ST, 32'hF6);
         look(8'h84, d, 2'b00);
      end
      // Multiprocessor format, no parity
      bus(1, CT, 32'h63);
      rx(d, 1'b0, 1'b1, 1'b1, 1'b1);
      look(8'hC6, d, 2'b00);
      bus(0, ST, 32'hC6);
      bus(1, ST, 32'hFD);
      bus(1, CT, 32'h62);
      look(8'hC7, d, 2'b00);
      dma_rx_read <= 1'b1;
      @(posedge clk);
      dma_rx_read <= 1'b0;
      bus(1, CT, 32'h63);
      bus(0, ST, 32'h87);
      bus(1, ST, 32'hA57F);
      @(negedge clk);
      chk(status_out[2], 1'b0);
      tx_wait();
      look(8'h87, d, 2'b00);
      chk(sent, 9'h1A5);
      rnd = xs(rnd);
      dma_tx_data <= rnd[7:0];
      dma_tx_write <= 1'b1;
      @(posedge clk);
      dma_tx_write <= 1'b0;
      @(negedge clk);
      chk(status_out[2], 1'b0);
      tx_wait();
      look(8'h87, d, 2'b00);
      chk(sent, {1'b1, rnd[7:0]});
      standby <= 1'b1;
      @(posedge clk);
      standby <= 1'b0;
      @(posedge clk);
      look(8'h84, d, 2'b00);
      summarize();
   end
endmodule
